/* File: hdl/mac_acc_pkg.sv */
`default_nettype none
package mac_acc_pkg;
    // -------------------------------------------------------------------
    // Register offsets, per unit
    // -------------------------------------------------------------------
    localparam logic [7:0] UNIT1_MUL_ONLY_X_OFS = 8'hA8;
    localparam logic [7:0] UNIT1_MUL_ONLY_Y_OFS = 8'hA9;
    localparam logic [7:0] UNIT1_ACC_X_OFS      = 8'hAC;
    localparam logic [7:0] UNIT1_ACC_Y_OFS      = 8'hAD;
    localparam logic [7:0] UNIT1_CLEAR_A_OFS    = 8'hAE;
    localparam logic [7:0] UNIT1_CLEAR_B_OFS    = 8'hAF;
    localparam logic [7:0] UNIT0_MUL_ONLY_X_OFS = 8'hE8;
    localparam logic [7:0] UNIT0_MUL_ONLY_Y_OFS = 8'hE9;
    localparam logic [7:0] UNIT0_ACC_X_OFS      = 8'hEC;
    localparam logic [7:0] UNIT0_ACC_Y_OFS      = 8'hED;
    localparam logic [7:0] UNIT0_CLEAR_A_OFS    = 8'hEE;
    localparam logic [7:0] UNIT0_CLEAR_B_OFS    = 8'hEF;
    // -------------------------------------------------------------------
    // Reset values and widths
    // -------------------------------------------------------------------
    localparam logic [31:0] ACC_RESET     = 32'h0000_0000;
    localparam logic [7:0]  OPERAND_RESET = 8'h00;
    localparam logic [7:0]  READ_IDLE     = 8'h00;
    localparam int          ACC_WIDTH     = 32;
    localparam int          OPERAND_WIDTH = 8;
endpackage
`default_nettype wire

/* File: hdl/mac_acc_decode.sv */
`default_nettype none
module mac_acc_decode
    import mac_acc_pkg::*;
#(
    parameter logic [7:0] BASE_MUL_X = 8'hE8,
    parameter logic [7:0] BASE_MUL_Y = 8'hE9,
    parameter logic [7:0] BASE_ACC_X = 8'hEC,
    parameter logic [7:0] BASE_ACC_Y = 8'hED,
    parameter logic [7:0] BASE_CLR_A = 8'hEE,
    parameter logic [7:0] BASE_CLR_B = 8'hEF
) (
    input  wire logic [7:0] addr,
    input  wire logic       wr_en,
    output logic            load_x,
    output logic            load_y,
    output logic            do_acc,
    output logic            do_clear,
    output logic            hit_b0,
    output logic            hit_b1,
    output logic            hit_b2,
    output logic            hit_b3
);
    // -------------------------------------------------------------------
    // Address match for one unit
    // -------------------------------------------------------------------
    // Either X alias loads X; same for Y
    assign load_x   = wr_en && (addr == BASE_MUL_X || addr == BASE_ACC_X);
    assign load_y   = wr_en && (addr == BASE_MUL_Y || addr == BASE_ACC_Y);
    assign do_acc   = wr_en && (addr == BASE_ACC_X || addr == BASE_ACC_Y);
    // Data value is ignored on clear writes
    assign do_clear = wr_en && (addr == BASE_CLR_A || addr == BASE_CLR_B);
    assign hit_b0   = (addr == BASE_ACC_Y);
    assign hit_b1   = (addr == BASE_ACC_X);
    assign hit_b2   = (addr == BASE_CLR_B);
    assign hit_b3   = (addr == BASE_CLR_A);
endmodule // mac_acc_decode
`default_nettype wire

/* File: hdl/mac_acc_product.sv */
`default_nettype none
module mac_acc_product
    import mac_acc_pkg::*;
#(
    parameter int OW = OPERAND_WIDTH,
    parameter int AW = ACC_WIDTH
) (
    input  wire logic signed [OW-1:0] a,
    input  wire logic signed [OW-1:0] b,
    output logic signed [AW-1:0]      prod_ext
);
    // -------------------------------------------------------------------
    // Signed product, sign-extended to accumulator width
    // -------------------------------------------------------------------
    logic signed [2*OW-1:0] prod;
    assign prod     = a * b;
    assign prod_ext = AW'(prod);
    // Refuse an accumulator that cannot hold the full product
    if (AW < 2*OW) begin : g_width_check
        $error("accumulator narrower than product");
    end
endmodule // mac_acc_product
`default_nettype wire

/* File: hdl/mac_acc_unit.sv */
`default_nettype none
module mac_acc_unit
    import mac_acc_pkg::*;
#(
    parameter logic [7:0] BASE_MUL_X = UNIT0_MUL_ONLY_X_OFS,
    parameter logic [7:0] BASE_MUL_Y = UNIT0_MUL_ONLY_Y_OFS,
    parameter logic [7:0] BASE_ACC_X = UNIT0_ACC_X_OFS,
    parameter logic [7:0] BASE_ACC_Y = UNIT0_ACC_Y_OFS,
    parameter logic [7:0] BASE_CLR_A = UNIT0_CLEAR_A_OFS,
    parameter logic [7:0] BASE_CLR_B = UNIT0_CLEAR_B_OFS
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [7:0]  addr,
    input  wire logic        wr_en,
    input  wire logic [7:0]  wr_data,
    output logic      [7:0]  rd_data,
    output logic      [7:0]  operand_x,
    output logic      [7:0]  operand_y,
    output logic      [31:0] acc_value
);
    // -------------------------------------------------------------------
    // Elaboration checks
    // -------------------------------------------------------------------
    // The state struct is laid out for 8-bit operands and a 32-bit sum
    if (ACC_WIDTH != 32 || OPERAND_WIDTH != 8) begin : g_width_check
        $error("unit needs 8-bit operands and a 32-bit accumulator");
    end

    // A shared address would make one write both load and clear
    if (BASE_MUL_X == BASE_MUL_Y || BASE_MUL_X == BASE_ACC_X
        || BASE_MUL_X == BASE_ACC_Y || BASE_MUL_X == BASE_CLR_A
        || BASE_MUL_X == BASE_CLR_B || BASE_MUL_Y == BASE_ACC_X
        || BASE_MUL_Y == BASE_ACC_Y || BASE_MUL_Y == BASE_CLR_A
        || BASE_MUL_Y == BASE_CLR_B || BASE_ACC_X == BASE_ACC_Y
        || BASE_ACC_X == BASE_CLR_A || BASE_ACC_X == BASE_CLR_B
        || BASE_ACC_Y == BASE_CLR_A || BASE_ACC_Y == BASE_CLR_B
        || BASE_CLR_A == BASE_CLR_B) begin : g_addr_check
        $error("unit register addresses must all differ");
    end

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef struct packed {
        logic signed [31:0] acc;
        logic        [7:0]  x;
        logic        [7:0]  y;
        logic        [7:0]  rd;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic               load_x;
    logic               load_y;
    logic               do_acc;
    logic               do_clear;
    logic               hit_b0;
    logic               hit_b1;
    logic               hit_b2;
    logic               hit_b3;
    logic        [7:0]  mul_a;
    logic        [7:0]  mul_b;
    logic signed [31:0] prod_ext;

    // -------------------------------------------------------------------
    // Address decode
    // -------------------------------------------------------------------
    mac_acc_decode #(
        .BASE_MUL_X (BASE_MUL_X),
        .BASE_MUL_Y (BASE_MUL_Y),
        .BASE_ACC_X (BASE_ACC_X),
        .BASE_ACC_Y (BASE_ACC_Y),
        .BASE_CLR_A (BASE_CLR_A),
        .BASE_CLR_B (BASE_CLR_B)
    ) u_dec (
        .addr     (addr),
        .wr_en    (wr_en),
        .load_x   (load_x),
        .load_y   (load_y),
        .do_acc   (do_acc),
        .do_clear (do_clear),
        .hit_b0   (hit_b0),
        .hit_b1   (hit_b1),
        .hit_b2   (hit_b2),
        .hit_b3   (hit_b3)
    );

    // -------------------------------------------------------------------
    // Multiplier
    // -------------------------------------------------------------------
    // New byte meets the other held operand, not its own old value
    assign mul_a = load_x ? wr_data : st_r.x;
    assign mul_b = load_y ? wr_data : st_r.y;

    mac_acc_product #(
        .OW (OPERAND_WIDTH),
        .AW (ACC_WIDTH)
    ) u_prod (
        .a        (mul_a),
        .b        (mul_b),
        .prod_ext (prod_ext)
    );

    // -------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------
    // Read data is registered: valid one cycle after the address
    always_comb begin
        st_nxt = st_r;
        if (load_x) begin
            st_nxt.x = wr_data;
        end
        if (load_y) begin
            st_nxt.y = wr_data;
        end
        if (do_clear) begin
            st_nxt.acc = ACC_RESET;
        end else if (do_acc) begin
            st_nxt.acc = st_r.acc + prod_ext;
        end
        if (hit_b0) begin
            st_nxt.rd = st_r.acc[7:0];
        end else if (hit_b1) begin
            st_nxt.rd = st_r.acc[15:8];
        end else if (hit_b2) begin
            st_nxt.rd = st_r.acc[23:16];
        end else if (hit_b3) begin
            st_nxt.rd = st_r.acc[31:24];
        end else begin
            st_nxt.rd = READ_IDLE;
        end
    end

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r.acc <= ACC_RESET;
            st_r.x   <= OPERAND_RESET;
            st_r.y   <= OPERAND_RESET;
            st_r.rd  <= READ_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    // Straight from the state flops, no logic after them
    assign rd_data   = st_r.rd;
    assign operand_x = st_r.x;
    assign operand_y = st_r.y;
    assign acc_value = st_r.acc;

    // -------------------------------------------------------------------
    // Reference values for the assertions
    // -------------------------------------------------------------------
    // Worked from the bus and the held outputs, apart from the decoder and
    // the operand mux, so a fault there cannot hide behind its own logic
    logic               ref_wr_x;
    logic               ref_wr_y;
    logic               ref_wr_acc;
    logic               ref_wr_clr;
    logic               ref_wr_mul;
    logic               ref_rd_map;
    logic signed [15:0] ref_prod;
    logic        [31:0] ref_prod_ext;

    // Write classes, one per address group
    assign ref_wr_x   = wr_en && (addr == BASE_MUL_X || addr == BASE_ACC_X);
    assign ref_wr_y   = wr_en && (addr == BASE_MUL_Y || addr == BASE_ACC_Y);
    assign ref_wr_acc = wr_en && (addr == BASE_ACC_X || addr == BASE_ACC_Y);
    assign ref_wr_clr = wr_en && (addr == BASE_CLR_A || addr == BASE_CLR_B);
    assign ref_wr_mul = wr_en && (addr == BASE_MUL_X || addr == BASE_MUL_Y);

    // Addresses that return an accumulator byte; all others read zero
    assign ref_rd_map = addr == BASE_ACC_X || addr == BASE_ACC_Y
                        || addr == BASE_CLR_A || addr == BASE_CLR_B;

    // New byte times the other held operand
    always_comb begin
        if (addr == BASE_ACC_X) begin
            ref_prod = $signed(wr_data) * $signed(operand_y);
        end else begin
            ref_prod = $signed(operand_x) * $signed(wr_data);
        end
    end

    // A size cast of a signed value widens with its sign
    assign ref_prod_ext = 32'(ref_prod);

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Accumulate write adds the sign-extended product
    acc_add_a : assert property (
        ref_wr_acc |=> acc_value == $past(acc_value) + $past(ref_prod_ext))
        else $error("accumulate result wrong");

    // From a zero sum the upper half copies the product sign
    acc_sext_a : assert property (
        ref_wr_acc && acc_value == ACC_RESET |=> acc_value[31:16] == {16{acc_value[15]}})
        else $error("product not sign-extended");

    // Nothing but an accumulate or a clear moves the sum
    acc_hold_a : assert property (
        !ref_wr_acc && !ref_wr_clr |=> $stable(acc_value))
        else $error("accumulator changed without cause");

    // Y address reads the low byte a cycle later
    rd_byte0_a : assert property (
        addr == BASE_ACC_Y |=> rd_data == $past(acc_value[7:0]))
        else $error("byte0 read wrong");

    // X address reads bits 15:8
    rd_byte1_a : assert property (
        addr == BASE_ACC_X |=> rd_data == $past(acc_value[15:8]))
        else $error("byte1 read wrong");

    // Clear B address reads bits 23:16
    rd_byte2_a : assert property (
        addr == BASE_CLR_B |=> rd_data == $past(acc_value[23:16]))
        else $error("byte2 read wrong");

    // Clear A address reads the top byte
    rd_byte3_a : assert property (
        addr == BASE_CLR_A |=> rd_data == $past(acc_value[31:24]))
        else $error("byte3 read wrong");

    // Any other address reads zero
    rd_other_a : assert property (
        !ref_rd_map |=> rd_data == READ_IDLE)
        else $error("unmapped read not zero");

    // Clear A zeroes the sum whatever the data
    clr_a_zero_a : assert property (
        wr_en && addr == BASE_CLR_A |=> acc_value == ACC_RESET)
        else $error("clear A failed");

    // Clear B zeroes the sum whatever the data
    clr_b_zero_a : assert property (
        wr_en && addr == BASE_CLR_B |=> acc_value == ACC_RESET)
        else $error("clear B failed");

    // Multiply-only X loads the shared X operand
    x_alias_a : assert property (
        wr_en && addr == BASE_MUL_X |=> operand_x == $past(wr_data))
        else $error("x alias not loaded");

    // Multiply-only Y loads the shared Y operand
    y_alias_a : assert property (
        wr_en && addr == BASE_MUL_Y |=> operand_y == $past(wr_data))
        else $error("y alias not loaded");

    // Accumulate X loads the same X operand
    acc_x_load_a : assert property (
        wr_en && addr == BASE_ACC_X |=> operand_x == $past(wr_data))
        else $error("accumulate x not loaded");

    // Accumulate Y loads the same Y operand
    acc_y_load_a : assert property (
        wr_en && addr == BASE_ACC_Y |=> operand_y == $past(wr_data))
        else $error("accumulate y not loaded");

    // X holds between its own writes
    x_keep_a : assert property (
        !ref_wr_x |=> $stable(operand_x))
        else $error("x operand changed without write");

    // Y holds between its own writes
    y_keep_a : assert property (
        !ref_wr_y |=> $stable(operand_y))
        else $error("y operand changed without write");

    // Multiply-only writes leave the sum alone
    mul_only_a : assert property (
        ref_wr_mul |=> $stable(acc_value))
        else $error("multiply-only write moved the sum");

    // -------------------------------------------------------------------
    // Cover points
    // -------------------------------------------------------------------
    // Back-to-back sums, clear after a sum, wrap, aliases, second clear
    acc_seen_c : cover property (do_acc ##1 do_acc);
    clr_seen_c : cover property (do_acc ##1 do_clear);
    wrap_seen_c : cover property (do_acc && acc_value[31] ##1 !acc_value[31]);
    alias_seen_c : cover property (ref_wr_mul);
    clr_b_seen_c : cover property (wr_en && addr == BASE_CLR_B);
endmodule // mac_acc_unit
`default_nettype wire

/* File: verification/mac_host_model.sv */
`default_nettype none
// ---------------------------------------------------------------
// Processor side of the register bus
// ---------------------------------------------------------------
module mac_host_model (
    input  wire logic       clk_sys,
    output logic      [7:0] addr,
    output logic            wr_en,
    output logic      [7:0] wr_data,
    input  wire logic [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bus starts on address 00, which no unit decodes; writes return to it, reads leave their address
    initial begin
        addr    = 8'h00;
        wr_en   = 1'b0;
        wr_data = 8'h00;
    end
    // One-cycle write strobe; stale data is inverted so it cannot pass
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr    <= a;
        wr_en   <= 1'b1;
        wr_data <= d;
        @(posedge clk_sys);
        wr_en   <= 1'b0;
        addr    <= 8'h00;
        wr_data <= ~d;
    endtask
    // Read byte is registered, so take it a cycle after the address
    task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wr_en <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        d = rd_data;
    endtask
endmodule // mac_host_model
`default_nettype wire

/* File: verification/mac_acc_unit_bench.sv */
`default_nettype none
module mac_acc_unit_bench
    import mac_acc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys;
    logic        rst_n = 1'b0;
    logic [7:0]  addr;
    logic        wr_en;
    logic [7:0]  wr_data;
    logic [7:0]  rd_data;
    logic [7:0]  operand_x;
    logic [7:0]  operand_y;
    logic [31:0] acc_value;
    logic [31:0] exp_acc = ACC_RESET;
    logic [7:0]  exp_x   = OPERAND_RESET;
    logic [7:0]  exp_y   = OPERAND_RESET;
    int          err_total = 0;
    int          tests_run = 0;
    mac_acc_unit u_mac_acc_unit (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
        .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data), .operand_x(operand_x),
        .operand_y(operand_y), .acc_value(acc_value));
    mac_host_model u_mac_host_model (.clk_sys(clk_sys), .addr(addr), .wr_en(wr_en),
        .wr_data(wr_data), .rd_data(rd_data));
    // 50 ns clock, reset held two cycles
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask
    // Operand write, mirrored in the expected state
    task automatic wr_op(input logic [7:0] a, input logic [7:0] d, input bit y, input bit acc);
        logic signed [15:0] p;
        u_mac_host_model.bus_write(a, d);
        if (y) exp_y = d;
        else exp_x = d;
        p = $signed(exp_x) * $signed(exp_y);
        if (acc) exp_acc = exp_acc + {{16{p[15]}}, p};
    endtask
    // Whole state plus the four byte windows; wait a half cycle so updates land
    task automatic chk_all;
        logic [7:0] b;
        @(negedge clk_sys);
        chk(acc_value, exp_acc);
        chk({16'h0000, operand_x, operand_y}, {16'h0000, exp_x, exp_y});
        u_mac_host_model.bus_read(UNIT0_ACC_Y_OFS, b);
        chk({24'h00_0000, b}, {24'h00_0000, exp_acc[7:0]});
        u_mac_host_model.bus_read(UNIT0_ACC_X_OFS, b);
        chk({24'h00_0000, b}, {24'h00_0000, exp_acc[15:8]});
        u_mac_host_model.bus_read(UNIT0_CLEAR_B_OFS, b);
        chk({24'h00_0000, b}, {24'h00_0000, exp_acc[23:16]});
        u_mac_host_model.bus_read(UNIT0_CLEAR_A_OFS, b);
        chk({24'h00_0000, b}, {24'h00_0000, exp_acc[31:24]});
    endtask
    // Mixed signs force sign extension into the upper bytes
    task automatic s_accumulate;
        wr_op(UNIT0_ACC_X_OFS, 8'h03, 1'b0, 1'b1);
        wr_op(UNIT0_ACC_Y_OFS, 8'hFB, 1'b1, 1'b1);
        chk_all();
        wr_op(UNIT0_ACC_X_OFS, 8'h80, 1'b0, 1'b1);
        wr_op(UNIT0_ACC_Y_OFS, 8'h7F, 1'b1, 1'b1);
        chk_all();
    endtask
    // Multiply-only writes load operands but leave the sum alone
    task automatic s_alias;
        wr_op(UNIT0_MUL_ONLY_X_OFS, 8'h05, 1'b0, 1'b0);
        wr_op(UNIT0_MUL_ONLY_Y_OFS, 8'hF9, 1'b1, 1'b0);
        chk_all();
        wr_op(UNIT0_ACC_X_OFS, 8'h7F, 1'b0, 1'b1);
        chk_all();
    endtask
    // The other unit's addresses must not touch this one
    task automatic s_unmapped;
        logic [7:0] b;
        u_mac_host_model.bus_write(UNIT1_ACC_X_OFS, 8'h11);
        u_mac_host_model.bus_write(UNIT1_CLEAR_A_OFS, 8'h22);
        chk_all();
        u_mac_host_model.bus_read(UNIT1_CLEAR_A_OFS, b);
        chk({24'h00_0000, b}, 32'h0000_0000);
    endtask
    // Both clear addresses, zero and all-ones data
    task automatic s_clear;
        logic [7:0] ca [2];
        ca = '{UNIT0_CLEAR_A_OFS, UNIT0_CLEAR_B_OFS};
        for (int i = 0; i < 2; i++) begin
            wr_op(UNIT0_ACC_Y_OFS, 8'h09, 1'b1, 1'b1);
            u_mac_host_model.bus_write(ca[i], (i == 0) ? 8'h00 : 8'hFF);
            exp_acc = ACC_RESET;
            chk_all();
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge clk_sys);
        chk_all();
        s_accumulate();
        s_alias();
        s_unmapped();
        s_clear();
        end_of_test();
    end
    // Watchdog, well past the hundred or so cycles the run needs
    initial begin
        repeat (3000) @(posedge clk_sys);
        err_total++;
        end_of_test();
    end
endmodule // mac_acc_unit_bench
`default_nettype wire
